// File: logic/dtr_pkg.sv
// constants shared by the d-type register primitives and their bus wrapper
package dtr_pkg;
	// bus geometry
	localparam int         AXI_ADDR_W = 4;
	localparam int         AXI_DATA_W = 32;
	// register byte offsets
	localparam logic [3:0] CTRL_OFFS  = 4'h0;
	localparam logic [3:0] STAT_OFFS  = 4'h4;
	// control register fields
	localparam int         CTRL_W           = 5;
	localparam logic [4:0] CTRL_RESET       = 5'h00;
	localparam int         CTRL_SW_CLEAR    = 0;
	localparam int         CTRL_SW_PRESET   = 1;
	localparam int         CTRL_SRC_SEL     = 2;
	localparam int         CTRL_SW_DATA     = 3;
	localparam int         CTRL_SW_ENABLE   = 4;
	// status register fields
	localparam int         STAT_CLEAR_Q     = 0;
	localparam int         STAT_PRESET_Q    = 1;
	localparam int         STAT_FALL_Q      = 2;
	// bus responses
	localparam logic [1:0] RESP_OKAY        = 2'h0;
	localparam logic [1:0] RESP_SLVERR      = 2'h2;
	// clear_preset_timing values
	localparam bit         TIMING_IMMEDIATE = 1'b0;
	localparam bit         TIMING_CLOCKED   = 1'b1;
	// power-up values
	localparam bit         INIT_CLEAR_REG   = 1'b0;
	localparam bit         INIT_PRESET_REG  = 1'b1;
	localparam bit         INIT_FALL_REG    = 1'b0;
endpackage

// File: logic/dtr_top.sv
// d-type register primitives and an axi4-lite wrapper that exercises them
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// rising edge, enable, active-low clear
module dtr_rise_enable_clear_reg import dtr_pkg::*; #(
	parameter bit INIT                = INIT_CLEAR_REG,
	parameter bit CLEAR_PRESET_TIMING = TIMING_IMMEDIATE
) (
	input  wire logic rising_clock_in,
	input  wire logic enable_in,
	input  wire logic data_in,
	input  wire logic clear_low_in,
	output logic      q
);
	logic q_r = INIT; // power-up value
	logic q_nxt;
	// clear first, then enable; covers both timing modes
	always_comb begin
		if (!clear_low_in)
			q_nxt = 1'b0;
		else if (enable_in)
			q_nxt = data_in;
		else
			q_nxt = q_r;
	end
		if (CLEAR_PRESET_TIMING == TIMING_IMMEDIATE) begin : g_async
			// clear acts without the clock
			always_ff @(posedge rising_clock_in or negedge clear_low_in) begin
				if (!clear_low_in)
					q_r <= 1'b0;
				else
					q_r <= q_nxt;
			end
		end else begin : g_sync
			always_ff @(posedge rising_clock_in) begin
				q_r <= q_nxt;
			end
		end
	assign q = q_r;
endmodule

// rising edge, enable, active-low preset
module dtr_rise_enable_preset_reg import dtr_pkg::*; #(
	parameter bit INIT                = INIT_PRESET_REG,
	parameter bit CLEAR_PRESET_TIMING = TIMING_IMMEDIATE
) (
	input  wire logic rising_clock_in,
	input  wire logic enable_in,
	input  wire logic data_in,
	input  wire logic preset_low_in,
	output logic      q
);
	logic q_r = INIT; // power-up value
	logic q_nxt;
	// preset wins over enable and data
	always_comb begin
		if (!preset_low_in)
			q_nxt = 1'b1;
		else if (enable_in)
			q_nxt = data_in;
		else
			q_nxt = q_r;
	end
		if (CLEAR_PRESET_TIMING == TIMING_IMMEDIATE) begin : g_async
			always_ff @(posedge rising_clock_in or negedge preset_low_in) begin
				if (!preset_low_in)
					q_r <= 1'b1;
				else
					q_r <= q_nxt;
			end
		end else begin : g_sync
			always_ff @(posedge rising_clock_in) begin
				q_r <= q_nxt;
			end
		end
	assign q = q_r;
endmodule

// falling edge, no enable, clear or preset
module dtr_fall_plain_reg import dtr_pkg::*; #(
	parameter bit INIT = INIT_FALL_REG
) (
	input  wire logic falling_clock_in,
	input  wire logic data_in,
	output logic      q
);
	logic q_r = INIT;
	logic q_nxt;
	always_comb begin
		q_nxt = data_in;
	end
	always_ff @(negedge falling_clock_in) begin
		q_r <= q_nxt;
	end
	assign q = q_r;
endmodule

// top: one instance of each variant behind an axi4-lite slave
module dtr_top import dtr_pkg::*; #(
	parameter bit CLEAR_TIMING = TIMING_IMMEDIATE,
	parameter bit PRESET_TIMING = TIMING_IMMEDIATE,
	parameter bit CLEAR_INIT   = INIT_CLEAR_REG,
	parameter bit PRESET_INIT  = INIT_PRESET_REG,
	parameter bit FALL_INIT    = INIT_FALL_REG
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  clk_en,
	input  wire logic                  data_in,
	input  wire logic                  enable_in,
	input  wire logic                  clear_low_in,
	input  wire logic                  preset_low_in,
	output logic                       clear_reg_q,
	output logic                       preset_reg_q,
	output logic                       fall_reg_q,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [AXI_DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready
);
	logic [CTRL_W-1:0]     ctrl_r, ctrl_nxt;
	logic                  aw_held_r, aw_held_nxt;
	logic                  w_held_r, w_held_nxt;
	logic [AXI_ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
	logic [AXI_DATA_W-1:0] w_data_r, w_data_nxt;
	logic                  w_lane0_r, w_lane0_nxt;
	logic                  awready_r, awready_nxt;
	logic                  wready_r, wready_nxt;
	logic                  bvalid_r, bvalid_nxt;
	logic [1:0]            bresp_r, bresp_nxt;
	logic                  arready_r, arready_nxt;
	logic                  rvalid_r, rvalid_nxt;
	logic [1:0]            rresp_r, rresp_nxt;
	logic [AXI_DATA_W-1:0] rdata_r, rdata_nxt;
	logic                  d_eff, en_eff, clr_eff, pre_eff, fall_d;
	// source select for data and enable: fabric pins or software fields; clear and preset take both
	assign d_eff   = ctrl_r[CTRL_SRC_SEL] ? ctrl_r[CTRL_SW_DATA] : data_in;
	assign en_eff  = clk_en & (ctrl_r[CTRL_SRC_SEL] ?
	                 ctrl_r[CTRL_SW_ENABLE] : enable_in);
	assign clr_eff = clear_low_in & ~ctrl_r[CTRL_SW_CLEAR];
	assign pre_eff = preset_low_in & ~ctrl_r[CTRL_SW_PRESET];
	// plain register has no enable, so freezing recirculates its own output
	assign fall_d  = clk_en ? d_eff : fall_reg_q;
	// variants kept apart so each truth table checks alone
	dtr_rise_enable_clear_reg #(
		.INIT                (CLEAR_INIT),
		.CLEAR_PRESET_TIMING (CLEAR_TIMING)
	) u_clear (
		.rising_clock_in (aclk),
		.enable_in       (en_eff),
		.data_in         (d_eff),
		.clear_low_in    (clr_eff),
		.q               (clear_reg_q)
	);
	dtr_rise_enable_preset_reg #(
		.INIT                (PRESET_INIT),
		.CLEAR_PRESET_TIMING (PRESET_TIMING)
	) u_preset (
		.rising_clock_in (aclk),
		.enable_in       (en_eff),
		.data_in         (d_eff),
		.preset_low_in   (pre_eff),
		.q               (preset_reg_q)
	);
	dtr_fall_plain_reg #(
		.INIT (FALL_INIT)
	) u_fall (
		.falling_clock_in (aclk),
		.data_in          (fall_d),
		.q                (fall_reg_q)
	);
	// write path: address and data held separately, either order
	always_comb begin
		ctrl_nxt    = ctrl_r;
		aw_held_nxt = aw_held_r | (s_axi_awvalid & awready_r);
		w_held_nxt  = w_held_r | (s_axi_wvalid & wready_r);
		aw_addr_nxt = (s_axi_awvalid & awready_r) ? s_axi_awaddr : aw_addr_r;
		w_data_nxt  = (s_axi_wvalid & wready_r) ? s_axi_wdata : w_data_r;
		w_lane0_nxt = (s_axi_wvalid & wready_r) ? s_axi_wstrb[0] : w_lane0_r;
		bvalid_nxt  = bvalid_r & ~s_axi_bready;
		bresp_nxt   = bresp_r;
		if (aw_held_r && w_held_r && !bvalid_r) begin
			aw_held_nxt = 1'b0;
			w_held_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = RESP_OKAY;
			if (aw_addr_r[AXI_ADDR_W-1:2] == CTRL_OFFS[AXI_ADDR_W-1:2]) begin
				if (w_lane0_r)
					ctrl_nxt = w_data_r[CTRL_W-1:0];
			end else if (aw_addr_r[AXI_ADDR_W-1:2] !=
			             STAT_OFFS[AXI_ADDR_W-1:2]) begin
				bresp_nxt = RESP_SLVERR; // unmapped
			end
		end
		// ready drops while a beat is parked, so the master holds the next
		awready_nxt = ~aw_held_nxt;
		wready_nxt  = ~w_held_nxt;
	end
	// read path: answer one cycle after the address is taken
	always_comb begin
		rvalid_nxt = rvalid_r & ~s_axi_rready;
		rresp_nxt  = rresp_r;
		rdata_nxt  = rdata_r;
		if (s_axi_arvalid && arready_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = RESP_OKAY;
			rdata_nxt  = '0;
			if (s_axi_araddr[AXI_ADDR_W-1:2] == CTRL_OFFS[AXI_ADDR_W-1:2])
				rdata_nxt[CTRL_W-1:0] = ctrl_r;
			else if (s_axi_araddr[AXI_ADDR_W-1:2] ==
			         STAT_OFFS[AXI_ADDR_W-1:2]) begin
				rdata_nxt[STAT_CLEAR_Q]  = clear_reg_q;
				rdata_nxt[STAT_PRESET_Q] = preset_reg_q;
				rdata_nxt[STAT_FALL_Q]   = fall_reg_q;
			end else
				rresp_nxt = RESP_SLVERR;
		end
		arready_nxt = ~rvalid_nxt;
	end
	// bus state; clock enable low stalls the bus as well
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r    <= CTRL_RESET;
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			aw_addr_r <= '0;
			w_data_r  <= '0;
			w_lane0_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rresp_r   <= RESP_OKAY;
			rdata_r   <= '0;
		end else if (clk_en) begin
			ctrl_r    <= ctrl_nxt;
			aw_held_r <= aw_held_nxt;
			w_held_r  <= w_held_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_data_r  <= w_data_nxt;
			w_lane0_r <= w_lane0_nxt;
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r  <= rvalid_nxt;
			rresp_r   <= rresp_nxt;
			rdata_r   <= rdata_nxt;
		end
	end
	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;
	// checks on the primitives and the bus
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
		if (CLEAR_TIMING == TIMING_IMMEDIATE) begin : g_chk_clr_imm
			property p_clr_now;
				!clr_eff |-> clear_reg_q == 1'b0;
			endproperty
			a_clr_now: assert property (p_clr_now)
				else $error("clear low but output not zero");
		end else begin : g_chk_clr_sync
			property p_clr_edge;
				!clr_eff && en_eff && d_eff |=> clear_reg_q == 1'b0;
			endproperty
			a_clr_edge: assert property (p_clr_edge)
				else $error("clocked clear did not load zero");
		end
		if (PRESET_TIMING == TIMING_IMMEDIATE) begin : g_chk_pre_imm
			property p_pre_now;
				!pre_eff |-> preset_reg_q == 1'b1;
			endproperty
			a_pre_now: assert property (p_pre_now)
				else $error("preset low but output not one");
		end else begin : g_chk_pre_sync
			property p_pre_edge;
				!pre_eff |=> preset_reg_q == 1'b1;
			endproperty
			a_pre_edge: assert property (p_pre_edge)
				else $error("clocked preset did not load one");
		end
	property p_clr_load;
		clr_eff && en_eff ##1 clr_eff |-> clear_reg_q == $past(d_eff);
	endproperty
	a_clr_load: assert property (p_clr_load)
		else $error("clear register missed its data");
	property p_clr_hold;
		clr_eff && !en_eff ##1 clr_eff |-> $stable(clear_reg_q);
	endproperty
	a_clr_hold: assert property (p_clr_hold)
		else $error("clear register changed with enable low");
	property p_pre_prio;
		!pre_eff && en_eff && !d_eff ##1 !pre_eff |-> preset_reg_q;
	endproperty
	a_pre_prio: assert property (p_pre_prio)
		else $error("data beat an asserted preset");
	property p_pre_load;
		pre_eff && en_eff ##1 pre_eff |-> preset_reg_q == $past(d_eff);
	endproperty
	a_pre_load: assert property (p_pre_load)
		else $error("preset register missed its data");
	property p_pre_hold;
		pre_eff && !en_eff ##1 pre_eff |-> $stable(preset_reg_q);
	endproperty
	a_pre_hold: assert property (p_pre_hold)
		else $error("preset register changed with enable low");
	property p_fall_copy;
		$past(aresetn) |-> fall_reg_q == fall_d;
	endproperty
	a_fall_copy: assert property (p_fall_copy)
		else $error("falling-edge register does not follow data");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready && clk_en |=>
			s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped before taken");
	property p_r_lat;
		s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid;
	endproperty
	a_r_lat: assert property (p_r_lat)
		else $error("read answer not one cycle after address");
	c_clear: cover property (!clr_eff ##1 clr_eff && en_eff && d_eff);
	c_preset: cover property (!pre_eff ##1 pre_eff && en_eff && !d_eff);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

`default_nettype wire

// File: test/dtr_fabric_model.sv
// fabric-side model that drives the register pins from requested levels
`timescale 1ns/1ps
`default_nettype none
module dtr_fabric_model (
	input  wire logic       aclk,
	input  wire logic [4:0] req,
	output logic            clk_en,
	output logic            preset_low_in,
	output logic            clear_low_in,
	output logic            enable_in,
	output logic            data_in
);
	// quiet levels from time zero: clock enabled, no clear, no preset, no load
	initial begin
		{clk_en, preset_low_in, clear_low_in, enable_in, data_in} = 5'h1c;
	end

	// launched just after the rising edge so every register sees settled pins
	always @(posedge aclk) begin
		{clk_en, preset_low_in, clear_low_in, enable_in, data_in} <= req;
	end
endmodule
`default_nettype wire

// File: test/dtr_tb_top.sv
// self-checking bench for the d-type registers behind the bus wrapper
`timescale 1ns/1ps
`default_nettype none
module dtr_tb_top import dtr_pkg::*; ;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        clk_en, data_in, enable_in, clear_low_in, preset_low_in;
	logic        clear_reg_q, preset_reg_q, fall_reg_q, pimm_q, csync_q;
	logic        ref_c, ref_p, ref_f, ref_pi, ref_cs;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [4:0]  req, ctrl_m, ctrl_pend;
	logic [31:0] s_axi_wdata, s_axi_rdata, r;
	int          fails, comparisons, seed, cyc;

	// 10 MHz clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	dtr_fabric_model fab (.aclk(aclk), .req(req), .clk_en(clk_en),
		.preset_low_in(preset_low_in), .clear_low_in(clear_low_in),
		.enable_in(enable_in), .data_in(data_in));
	// main wrapper: immediate clear, clocked preset
	dtr_top #(.PRESET_TIMING(TIMING_CLOCKED)) dut (.aclk(aclk),
		.aresetn(aresetn), .clk_en(clk_en), .data_in(data_in),
		.enable_in(enable_in), .clear_low_in(clear_low_in),
		.preset_low_in(preset_low_in), .clear_reg_q(clear_reg_q),
		.preset_reg_q(preset_reg_q), .fall_reg_q(fall_reg_q),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	// second wrapper on the same pins and bus: clocked clear, immediate preset
	dtr_top #(.CLEAR_TIMING(TIMING_CLOCKED)) dut_alt (.aclk(aclk),
		.aresetn(aresetn), .clk_en(clk_en), .data_in(data_in),
		.enable_in(enable_in), .clear_low_in(clear_low_in),
		.preset_low_in(preset_low_in), .clear_reg_q(csync_q),
		.preset_reg_q(pimm_q), .fall_reg_q(),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
		.s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
		.s_axi_rready(s_axi_rready));

	// effective levels the wrapper hands its registers
	function automatic logic eff_d();
		return ctrl_m[CTRL_SRC_SEL] ? ctrl_m[CTRL_SW_DATA] : data_in;
	endfunction
	function automatic logic eff_en();
		return clk_en & (ctrl_m[CTRL_SRC_SEL] ?
			ctrl_m[CTRL_SW_ENABLE] : enable_in);
	endfunction
	function automatic logic clr_n();
		return clear_low_in & ~ctrl_m[CTRL_SW_CLEAR];
	endfunction
	function automatic logic pre_n();
		return preset_low_in & ~ctrl_m[CTRL_SW_PRESET];
	endfunction
	function automatic logic [31:0] stat_exp();
		return {29'h0, ref_f, ref_p, clr_n() & ref_c};
	endfunction

	task automatic chk1(input string n, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic chkw(input string n, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wrap_up();
		if (fails == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// rising-edge reference; a hang ends in the cycle ceiling
	always @(posedge aclk) begin
		cyc++;
		if (!clr_n()) ref_c = 1'b0;
		else if (eff_en()) ref_c = eff_d();
		if (!pre_n()) ref_p = 1'b1;
		else if (eff_en()) ref_p = eff_d();
		if (!pre_n()) ref_pi = 1'b1;
		else if (eff_en()) ref_pi = eff_d();
		if (!clr_n()) ref_cs = 1'b0;
		else if (eff_en()) ref_cs = eff_d();
		if (!aresetn) ctrl_m = CTRL_RESET;
		if (cyc >= 5000) begin
			fails++;
			wrap_up();
		end
	end

	// mid-cycle compare catches immediate clear/preset with no edge
	always @(negedge aclk) begin
		if (s_axi_bvalid === 1'b1) ctrl_m = ctrl_pend;
		chk1("clear_reg_q", clr_n() & ref_c, clear_reg_q);
		chk1("preset_reg_q", ref_p, preset_reg_q);
		chk1("preset_imm_q", ~pre_n() | ref_pi, pimm_q);
		chk1("clear_sync_q", ref_cs, csync_q);
		chk1("fall_reg_q", ref_f, fall_reg_q);
		if (clk_en) ref_f = eff_d();
	end

	task automatic axw(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er, input logic [4:0] nc);
		bit dn;
		dn = 0;
		@(posedge aclk);
		ctrl_pend <= nc;
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
		{s_axi_awvalid, s_axi_wvalid} <= 2'h3;
		while (!dn) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
				chkw("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
				s_axi_bready <= 1'b0;
				dn = 1;
			end else if (s_axi_bvalid === 1'b1)
				s_axi_bready <= 1'b1; // late ready: response must wait
		end
	endtask
	task automatic axr(input logic [3:0] a, input logic [31:0] e,
		input logic [1:0] er);
		bit dn;
		dn = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		while (!dn) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				chkw("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
				if (er == RESP_OKAY) chkw("rdata", e, s_axi_rdata);
				s_axi_rready <= 1'b0;
				dn = 1;
			end
		end
	endtask
	// random pins, clear and preset low a quarter of the time; ends quiet
	task automatic phase(input int n, input bit ce_rnd);
		repeat (n) begin
			@(posedge aclk);
			r = $random(seed);
			req <= {r[4] | ~ce_rnd, |r[6:5], |r[8:7], r[1], r[0]};
		end
		@(posedge aclk);
		req <= 5'h1c;
	endtask

	// main sequence
	initial begin
		{seed, fails, comparisons, cyc} = {32'd42, 96'd0};
		aresetn = 1'b0;
		req = 5'h1c;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h000;
		s_axi_wdata = 32'h0000_0000;
		{ctrl_m, ctrl_pend} = {CTRL_RESET, CTRL_RESET};
		{ref_c, ref_p, ref_f, ref_pi, ref_cs} = 5'h0a;
		#80;
		chk1("clear_init", 1'b0, clear_reg_q);
		chk1("preset_init", 1'b1, preset_reg_q);
		chk1("fall_init", 1'b0, fall_reg_q);
		chk1("preset_imm_init", 1'b1, pimm_q);
		chk1("clear_sync_init", 1'b0, csync_q);
		repeat (11) @(posedge aclk);
		aresetn <= 1'b1;
		axr(CTRL_OFFS, 32'h0000_0000, RESP_OKAY);
		phase(300, 1'b0);
		// every control code, read back then exercised with stalls
		for (int i = 0; i < 32; i++) begin
			axw(CTRL_OFFS, 32'(i), 4'hf, RESP_OKAY, 5'(i));
			axr(CTRL_OFFS, 32'(i), RESP_OKAY);
			phase(8, 1'b1);
		end
		axw(CTRL_OFFS, 32'h0000_0000, 4'hf, RESP_OKAY, 5'h00);
		axw(4'h8, 32'hffff_ffff, 4'hf, RESP_SLVERR, ctrl_m);
		axw(STAT_OFFS, 32'hffff_ffff, 4'hf, RESP_OKAY, ctrl_m);
		axw(CTRL_OFFS, 32'hffff_ffff, 4'he, RESP_OKAY, ctrl_m);
		axr(4'hc, 32'h0000_0000, RESP_SLVERR);
		axr(CTRL_OFFS, 32'h0000_0000, RESP_OKAY);
		repeat (6) begin
			phase(40, 1'b1);
			repeat (3) @(posedge aclk);
			axr(STAT_OFFS, stat_exp(), RESP_OKAY);
		end
		axw(CTRL_OFFS, 32'h0000_001c, 4'hf, RESP_OKAY, 5'h1c);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axr(CTRL_OFFS, 32'h0000_0000, RESP_OKAY);
		phase(100, 1'b1);
		wrap_up();
	end
endmodule
`default_nettype wire
